// File: rtl/dcag_pkg.sv
// Package for the DMA channel address generator
package dcag_pkg;
  // ----------------------------------------
  // Bus and address widths
  // ----------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int MADDR_W = 24;
  localparam int OFFS_W = 12;
  localparam int CNT_W = 14;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STA_OFF = 8'h04;
  localparam logic [7:0] STB_OFF = 8'h08;
  localparam logic [7:0] PAD_OFF = 8'h0c;
  localparam logic [7:0] CNT_OFF = 8'h10;
  localparam logic [7:0] STAT_OFF = 8'h14;
  localparam logic [7:0] IRQST_OFF = 8'h18;
  localparam logic [7:0] IRQMSK_OFF = 8'h1c;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int CTL_EN_BIT = 15;
  localparam int CTL_SIZE_BIT = 14;
  localparam int CTL_DIR_BIT = 13;
  localparam int CTL_HALF_BIT = 12;
  localparam int CTL_AM_LO = 4;
  localparam int CTL_AM_HI = 5;
  localparam int CTL_MODE_LO = 0;
  localparam int CTL_MODE_HI = 1;
  localparam logic [15:0] CTL_RST = 16'h0000;

  // ----------------------------------------
  // Modes and steps
  // ----------------------------------------
  typedef enum logic [1:0] {
    DCAG_AM_POSTINC = 2'h0,
    DCAG_AM_FIXED   = 2'h1,
    DCAG_AM_PIA     = 2'h2,
    DCAG_AM_PIA2    = 2'h3
  } dcag_am_e;
  localparam logic [MADDR_W-1:0] STEP_WORD = 24'h000002;
  localparam logic [MADDR_W-1:0] STEP_BYTE = 24'h000001;

  // Interrupt status bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_HALF_BIT = 1;
  localparam logic [1:0] IRQ_RST = 2'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: rtl/dcag_addr_reg.sv
// Working address register with per-mode update
`timescale 1ns/1ns
module dcag_addr_reg
  import dcag_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               load,
  input  wire logic [MADDR_W-1:0] load_val,
  input  wire logic               step,
  input  wire logic [1:0]         am,
  input  wire logic               byte_size,
  output logic      [MADDR_W-1:0] addr
);
  logic [MADDR_W-1:0] addr_reg;
  logic [MADDR_W-1:0] addr_next;
  wire  [MADDR_W-1:0] step_amt = byte_size ? STEP_BYTE : STEP_WORD;
  // Fixed and indirect keep the base; only post-increment advances
  wire adv = step && (am == DCAG_AM_POSTINC);

  assign addr_next = load ? load_val :
                     adv  ? addr_reg + step_amt : addr_reg;
  assign addr = addr_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_reg <= '0;
    end else begin
      addr_reg <= addr_next;
    end
  end

  a_fixed_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    step && !load && am == DCAG_AM_FIXED |=> addr == $past(addr))
    else $error("fixed mode address moved");
endmodule

// File: rtl/dcag_top.sv
// DMA channel memory-side address generator with AXI4-Lite registers
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module dcag_top
  import dcag_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               req_valid,
  output logic                    req_ready,
  input  wire logic [OFFS_W-1:0]  req_offset,
  output logic                    xfer_valid,
  input  wire logic               xfer_ready,
  output logic [MADDR_W-1:0]      mem_addr,
  output logic [15:0]             periph_addr,
  output logic                    mem_write,
  output logic                    byte_xfer,
  output logic                    irq
);
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [15:0]        ctrl_reg;
  logic [MADDR_W-1:0] sta_reg;
  logic [MADDR_W-1:0] stb_reg;
  logic [15:0]        pad_reg;
  logic [CNT_W-1:0]   cnt_reg;
  logic [MADDR_W-1:0] last_reg;
  logic [1:0]         irqst_reg;
  logic [1:0]         irqmsk_reg;
  logic [CNT_W-1:0]   done_reg;
  logic               pp_reg;
  logic               busy_reg;
  logic [MADDR_W-1:0] base_reg;

  wire [1:0] am = ctrl_reg[CTL_AM_HI:CTL_AM_LO];
  wire [1:0] chmode = ctrl_reg[CTL_MODE_HI:CTL_MODE_LO];
  wire en = ctrl_reg[CTL_EN_BIT];
  wire pia = am[1];
  wire oneshot = chmode[0];
  wire pingpong = chmode[1];

  function automatic logic [DATA_W-1:0] wmerge(
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] nw,
    input logic [3:0]        st);
    logic [DATA_W-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] rsel(input logic [7:0] off);
    logic [3:0] k;
    k = 4'hf;
    unique case (off)
      CTRL_OFF:   k = 4'h0;
      STA_OFF:    k = 4'h1;
      STB_OFF:    k = 4'h2;
      PAD_OFF:    k = 4'h3;
      CNT_OFF:    k = 4'h4;
      STAT_OFF:   k = 4'h5;
      IRQST_OFF:  k = 4'h6;
      IRQMSK_OFF: k = 4'h7;
      default:    k = 4'hf;
    endcase
    return k;
  endfunction

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  logic              aw_have_reg;
  logic              w_have_reg;
  logic [7:0]        awa_reg;
  logic [DATA_W-1:0] wd_reg;
  logic [3:0]        ws_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;

  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready = !w_have_reg && !bvalid_reg;
  wire wr_go = aw_have_reg && w_have_reg && !bvalid_reg;
  wire [3:0] wsel = rsel(awa_reg);
  wire wr_ctrl = wr_go && wsel == 4'h0;
  wire wr_sta = wr_go && wsel == 4'h1;
  wire wr_stb = wr_go && wsel == 4'h2;
  wire wr_pad = wr_go && wsel == 4'h3;
  wire wr_cnt = wr_go && wsel == 4'h4;
  wire wr_ist = wr_go && wsel == 4'h6;
  wire wr_msk = wr_go && wsel == 4'h7;
  wire [DATA_W-1:0] ctrl_m = wmerge({16'h0000, ctrl_reg}, wd_reg, ws_reg);
  wire [DATA_W-1:0] sta_m = wmerge({8'h00, sta_reg}, wd_reg, ws_reg);
  wire [DATA_W-1:0] stb_m = wmerge({8'h00, stb_reg}, wd_reg, ws_reg);
  wire [DATA_W-1:0] pad_m = wmerge({16'h0000, pad_reg}, wd_reg, ws_reg);
  wire [DATA_W-1:0] cnt_m = wmerge({18'h00000, cnt_reg}, wd_reg, ws_reg);
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awa_reg <= 8'h00;
      wd_reg <= '0;
      ws_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awa_reg <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wd_reg <= s_axi_wdata;
        ws_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (wsel == 4'hf) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  logic              rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0]        rresp_reg;
  assign s_axi_arready = !rvalid_reg;
  wire [3:0] rs = rsel(s_axi_araddr[7:0]);
  // Start-address reads show the last transfer address
  wire [DATA_W-1:0] rd_mux =
    rs == 4'h0 ? {16'h0000, ctrl_reg} :
    rs == 4'h1 ? {8'h00, last_reg} :
    rs == 4'h2 ? {8'h00, last_reg} :
    rs == 4'h3 ? {16'h0000, pad_reg} :
    rs == 4'h4 ? {18'h00000, cnt_reg} :
    rs == 4'h5 ? {16'h0000, pp_reg, busy_reg, done_reg} :
    rs == 4'h6 ? {30'h00000000, irqst_reg} :
    rs == 4'h7 ? {30'h00000000, irqmsk_reg} : '0;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= (rs == 4'hf) ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Transfer sequencing
  // ----------------------------------------
  logic [OFFS_W-1:0] offs_reg;
  logic              pend_reg;
  logic [MADDR_W-1:0] waddr;
  assign req_ready = en && busy_reg && !pend_reg;
  wire take = req_valid && req_ready;
  wire fire = pend_reg && xfer_ready;
  wire last_x = done_reg == cnt_reg;
  // Odd element counts round the half point down
  wire [CNT_W-1:0] half_pt = CNT_W'((cnt_reg + 1'b1) >> 1) - 1'b1;
  wire [MADDR_W-1:0] sel_start = pp_reg ? stb_reg : sta_reg;
  wire [MADDR_W-1:0] offs_ext = {{(MADDR_W-OFFS_W){1'b0}}, req_offset};
  // Offset kept only in indirect mode; base assumed aligned by software
  wire [MADDR_W-1:0] cur_addr = pia ? (base_reg | offs_ext)
                                    : waddr;
  wire start = wr_ctrl && ctrl_m[CTL_EN_BIT] && !en;
  wire blk_new = fire && last_x && !oneshot;
  wire nxt_pp = pingpong ? !pp_reg : pp_reg;
  // Reload only on start or block end, so a mode change keeps the live address
  wire wl_load = start || blk_new;
  wire [MADDR_W-1:0] wl_val = start ? sta_reg : nxt_pp ? stb_reg : sta_reg;

  dcag_addr_reg u_addr (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .load      (wl_load),
    .load_val  (wl_val),
    .step      (fire),
    .am        (am),
    .byte_size (ctrl_reg[CTL_SIZE_BIT]),
    .addr      (waddr)
  );

  assign xfer_valid = pend_reg;
  assign mem_addr = last_reg;
  assign periph_addr = pad_reg;
  assign mem_write = !ctrl_reg[CTL_DIR_BIT];
  assign byte_xfer = ctrl_reg[CTL_SIZE_BIT];
  wire ev_half = fire && ctrl_reg[CTL_HALF_BIT] && done_reg == half_pt;
  wire ev_done = fire && !ctrl_reg[CTL_HALF_BIT] && last_x;
  assign irq = |(irqst_reg & irqmsk_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTL_RST;
      sta_reg <= '0;
      stb_reg <= '0;
      pad_reg <= 16'h0000;
      cnt_reg <= '0;
      irqmsk_reg <= IRQ_RST;
    end else begin
      if (wr_ctrl) ctrl_reg <= ctrl_m[15:0];
      else if (fire && last_x && oneshot) ctrl_reg[CTL_EN_BIT] <= 1'b0;
      if (wr_sta) sta_reg <= sta_m[MADDR_W-1:0];
      if (wr_stb) stb_reg <= stb_m[MADDR_W-1:0];
      if (wr_pad) pad_reg <= pad_m[15:0];
      if (wr_cnt) cnt_reg <= cnt_m[CNT_W-1:0];
      if (wr_msk) irqmsk_reg <= wd_reg[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      offs_reg <= '0;
      pend_reg <= 1'b0;
      last_reg <= '0;
    end else begin
      if (take) offs_reg <= req_offset;
      if (take) pend_reg <= 1'b1;
      else if (fire) pend_reg <= 1'b0;
      if (take) last_reg <= cur_addr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_reg <= 1'b0;
      done_reg <= '0;
      pp_reg <= 1'b0;
      base_reg <= '0;
      irqst_reg <= IRQ_RST;
    end else begin
      if (start) begin
        busy_reg <= 1'b1;
        done_reg <= '0;
        pp_reg <= 1'b0;
        base_reg <= sta_reg;
      end else if (wr_ctrl && !ctrl_m[CTL_EN_BIT]) begin
        busy_reg <= 1'b0;
      end else if (fire) begin
        done_reg <= last_x ? '0 : done_reg + 1'b1;
        if (last_x && oneshot) busy_reg <= 1'b0;
        if (last_x) pp_reg <= nxt_pp;
        if (last_x) base_reg <= nxt_pp ? stb_reg : sta_reg;
      end
      // Set wins over a simultaneous write-one clear
      irqst_reg <= (irqst_reg & ~(wr_ist ? wd_reg[1:0] : 2'h0))
                   | {ev_half, ev_done};
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_pia_or_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    take && pia |=> mem_addr == (base_reg | {{(MADDR_W-OFFS_W){1'b0}},
                                  $past(req_offset)}))
    else $error("indirect address not base OR offset");
  a_offs_ignore: assert property (@(posedge aclk) disable iff (!aresetn)
    take && !pia |=> mem_addr == $past(waddr))
    else $error("offset used outside indirect mode");
  a_post_step: assert property (@(posedge aclk) disable iff (!aresetn)
    fire && am == DCAG_AM_POSTINC && !wl_load && !byte_xfer
      |=> waddr == $past(waddr) + STEP_WORD)
    else $error("word step not two");
  a_reset_mode: assert property (@(posedge aclk)
    !aresetn |=> am == DCAG_AM_POSTINC)
    else $error("mode after reset not post-increment");
  a_offs_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    take |=> offs_reg == $past(req_offset) && xfer_valid)
    else $error("offset not captured on accept");
  a_dir_map: assert property (@(posedge aclk) disable iff (!aresetn)
    mem_write == !ctrl_reg[CTL_DIR_BIT])
    else $error("direction mapping wrong");
  a_done_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_done |=> irqst_reg[IRQ_DONE_BIT])
    else $error("done flag not set");
  a_start_load: assert property (@(posedge aclk) disable iff (!aresetn)
    start |=> waddr == $past(sta_reg))
    else $error("working address not loaded");
  c_pia_xfer: cover property (@(posedge aclk) take && pia ##[1:4] fire);
  c_fixed_xfer: cover property (@(posedge aclk)
    fire && am == DCAG_AM_FIXED);
  c_block_end: cover property (@(posedge aclk) fire && last_x);
endmodule

// File: testbench/dcag_periph_model.sv
// Peripheral model issuing DMA requests with an address offset
`timescale 1ns/1ns
module dcag_periph_model
  import dcag_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              go,
  input  wire logic [OFFS_W-1:0] offs,
  input  wire logic              req_ready,
  output logic                   req_valid,
  output logic      [OFFS_W-1:0] req_offset
);
  // ----------------------------------------
  // Request with offset, held until taken
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_valid  <= 1'b0;
      req_offset <= '0;
    end else if (req_valid && req_ready) begin
      // Stale offset after release exposes late sampling
      req_valid  <= 1'b0;
      req_offset <= ~req_offset;
    end else if (go && !req_valid) begin
      req_valid  <= 1'b1;
      req_offset <= offs;
    end
  end
endmodule

// File: testbench/dcag_top_test.sv
// Self-checking bench of the channel address generator
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module dcag_top_test
  import dcag_pkg::*;
;
  logic               aclk, aresetn, go;
  logic [OFFS_W-1:0]  offs;
  logic [ADDR_W-1:0]  s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0]  s_axi_wdata, s_axi_rdata;
  logic [3:0]         s_axi_wstrb;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic               s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic               s_axi_rready, req_valid, req_ready, xfer_valid;
  logic               xfer_ready, mem_write, byte_xfer, irq;
  logic [OFFS_W-1:0]  req_offset;
  logic [MADDR_W-1:0] mem_addr;
  logic [15:0]        periph_addr;
  int                 err_count = 0;
  int                 checked = 0;

  dcag_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_valid, .req_ready,
    .req_offset, .xfer_valid, .xfer_ready, .mem_addr, .periph_addr,
    .mem_write, .byte_xfer, .irq);
  dcag_periph_model periph (.aclk, .aresetn, .go, .offs, .req_ready,
    .req_valid, .req_offset);

  // ----------------------------------------
  // Bus and transfer tasks
  // ----------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr  <= {24'h000000, a};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bvalid, 1'b1)
    `CHK(s_axi_bresp, RESP_OKAY)
    repeat (2) @(posedge aclk);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    int n;
    s_axi_araddr  <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rvalid, 1'b1)
    `CHK(s_axi_rdata, ed)
    `CHK(s_axi_rresp, er)
    @(posedge aclk);
  endtask

  // Memory side stalls two cycles so a stale offset would show
  task automatic xfer(input logic [OFFS_W-1:0] off,
                      input logic [MADDR_W-1:0] exp);
    int n;
    go   <= 1'b1;
    offs <= off;
    @(posedge aclk);
    go <= 1'b0;
    n = 0;
    while (xfer_valid !== 1'b1 && n < 50) begin
      @(posedge aclk);
      n++;
    end
    @(posedge aclk);
    `CHK(xfer_valid, 1'b1)
    `CHK(mem_addr, exp)
    xfer_ready <= 1'b1;
    @(posedge aclk);
    xfer_ready <= 1'b0;
    @(posedge aclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    `CHK(irq, 1'b0)
    axr(CTRL_OFF, 32'h00000000, RESP_OKAY);
    axr(8'h20, 32'h00000000, RESP_SLVERR);
  endtask

  task automatic t_postinc_fixed;
    axw(CNT_OFF, 32'h0000000f);
    axw(STA_OFF, 32'h00000100);
    axw(PAD_OFF, 32'h00001234);
    axw(CTRL_OFF, 32'h00008000);
    xfer(12'h3ff, 24'h000100);
    xfer(12'h000, 24'h000102);
    `CHK(mem_write, 1'b1)
    `CHK(periph_addr, 16'h1234)
    axr(STA_OFF, 32'h00000102, RESP_OKAY);
    // Mode change while active: no reload from the start register
    axw(CTRL_OFF, 32'h0000a010);
    xfer(12'h0f0, 24'h000104);
    xfer(12'h00f, 24'h000104);
    `CHK(mem_write, 1'b0)
  endtask

  task automatic t_byte;
    axw(CTRL_OFF, 32'h00000000);
    axw(CTRL_OFF, 32'h0000c000);
    xfer(12'h000, 24'h000100);
    xfer(12'h000, 24'h000101);
    `CHK(byte_xfer, 1'b1)
    axr(STA_OFF, 32'h00000101, RESP_OKAY);
  endtask

  task automatic t_pia;
    logic [OFFS_W-1:0]  off;
    logic [MADDR_W-1:0] e;
    for (int am = 2; am < 4; am++) begin
      for (int d = 0; d < 2; d++) begin
        off = 12'h0a5 + 12'(am * 4 + d) * 12'h111;
        e   = 24'h001000 | {12'h000, off};
        axw(CTRL_OFF, 32'h00000000);
        axw(STA_OFF, 32'h00001000);
        axw(CTRL_OFF, 32'h8000 | (d << CTL_DIR_BIT) | (am << CTL_AM_LO));
        xfer(off, e);
        `CHK(mem_write, logic'(d == 0))
        axr(STA_OFF, 32'(e), RESP_OKAY);
      end
    end
  endtask

  task automatic t_irq;
    axw(CTRL_OFF, 32'h00000000);
    axw(IRQST_OFF, 32'h00000003);
    axw(IRQMSK_OFF, 32'h00000000);
    axw(CNT_OFF, 32'h00000000);
    axw(STA_OFF, 32'h00000200);
    axw(CTRL_OFF, 32'h00008020);
    xfer(12'h055, 24'h000255);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    axr(IRQST_OFF, 32'h00000001, RESP_OKAY);
    axw(IRQMSK_OFF, 32'h00000001);
    `CHK(irq, 1'b1)
    axw(IRQST_OFF, 32'h00000001);
    `CHK(irq, 1'b0)
    axr(IRQST_OFF, 32'h00000000, RESP_OKAY);
  endtask

  // Ping-pong with half interrupt, then a one-shot block end
  task automatic t_modes;
    axw(CTRL_OFF, 32'h00000000);
    axw(IRQST_OFF, 32'h00000003);
    axw(IRQMSK_OFF, 32'h00000002);
    axw(CNT_OFF, 32'h00000001);
    axw(STA_OFF, 32'h00002000);
    axw(STB_OFF, 32'h00003000);
    axw(CTRL_OFF, 32'h00009022);
    xfer(12'h010, 24'h002010);
    `CHK(irq, 1'b1)
    xfer(12'h020, 24'h002020);
    xfer(12'h030, 24'h003030);
    axr(STAT_OFF, 32'h0000c001, RESP_OKAY);
    axr(IRQST_OFF, 32'h00000002, RESP_OKAY);
    axw(IRQST_OFF, 32'h00000002);
    `CHK(irq, 1'b0)
    axw(CTRL_OFF, 32'h00000000);
    axw(CNT_OFF, 32'h00000000);
    axw(CTRL_OFF, 32'h00008001);
    xfer(12'h7ff, 24'h002000);
    `CHK(req_ready, 1'b0)
    axr(CTRL_OFF, 32'h00000001, RESP_OKAY);
    axr(IRQST_OFF, 32'h00000001, RESP_OKAY);
    `CHK(irq, 1'b0)
  endtask

  // Reset with the channel disabled and mode 3 set must bring back post-increment mode
  task automatic t_rereset;
    axw(CTRL_OFF, 32'h00000030);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(irq, 1'b0)
    axr(CTRL_OFF, 32'h00000000, RESP_OKAY);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, reset, sequence, watchdog
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial begin
    aresetn = 1'b0;
    go = 1'b0;
    offs = '0;
    xfer_ready = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_postinc_fixed();
    t_byte();
    t_pia();
    t_irq();
    t_modes();
    t_rereset();
    final_report();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    final_report();
  end
endmodule
